// ===== core/usir_cfg.svh
/*
  Offsets, field positions, reset values and timing figures of the serial
  transceiver with infrared pulse coder.
  Assumes a 32-bit APB register bus with 12-bit byte addresses.
*/
`ifndef USIR_CFG_SVH
`define USIR_CFG_SVH

// Register byte offsets
`define USIR_OFF_DATA 12'h000
`define USIR_OFF_STATUS 12'h004
`define USIR_OFF_MASK 12'h008
`define USIR_OFF_CTRL 12'h00c
`define USIR_OFF_BAUD 12'h010
`define USIR_OFF_IRPULSE 12'h014

// Control fields
`define USIR_F_TXEN 0
`define USIR_F_RXEN 1
`define USIR_F_MODE 3:2
`define USIR_F_SIZE 6:4
`define USIR_F_STOP2 7
`define USIR_F_PAR 9:8
`define USIR_F_MPCM 10
`define USIR_F_LSBF 11
`define USIR_F_IREN 12
`define USIR_F_IRSEL 14:13
`define USIR_CTRL_W 15

// Field codes
`define USIR_MODE_ASYNC 2'h0
`define USIR_MODE_SMASTER 2'h1
`define USIR_MODE_SSLAVE 2'h2
`define USIR_MODE_SPI 2'h3
`define USIR_PAR_EVEN 2'h2
`define USIR_PAR_ODD 2'h3
`define USIR_IR_316 2'h0
`define USIR_IR_FIXED 2'h1
`define USIR_IR_BYPASS 2'h2

// Baud fields: integer divisor and sixteenths
`define USIR_F_BINT 11:0
`define USIR_F_BFRAC 15:12

// Status bits, sticky, write one to clear
`define USIR_ST_RXC 0
`define USIR_ST_TXC 1
`define USIR_ST_DRE 2
`define USIR_ST_FERR 3
`define USIR_ST_PERR 4
`define USIR_ST_OVF 5
`define USIR_ST_W 6

// Reset values
`define USIR_CTRL_RST 15'h0000
`define USIR_BAUD_RST 16'h0010
`define USIR_IRPULSE_RST 8'h10
`define USIR_MASK_RST 6'h00

// Samples per asynchronous bit; sampling phases of the majority vote
`define USIR_PH_LAST 3'h7
`define USIR_PH_VOTE 3'h5
`define USIR_IR_LOW_TICKS 4'h8

`endif

// ===== core/usir_pkg.sv
/*
  Types of the serial transceiver with infrared pulse coder.
  Assumes usir_cfg.svh for all numeric constants.
*/
`default_nettype none
package usir_pkg;

  // Frame position of the transmitter and the receiver
  typedef enum logic [2:0] {
    usir_idle,
    usir_start,
    usir_data,
    usir_par,
    usir_stop
  } usir_frame_t;

endpackage : usir_pkg
`default_nettype wire

// ===== core/usir_top.sv
/*
  Serial transceiver: asynchronous, synchronous master/slave and master SPI
  framing, fractional baud generator, infrared pulse coder, APB registers.
  Assumes pins synchronous to clk, a single clock and an APB master.
*/
`timescale 1ns/100ps
`default_nettype none
`include "usir_cfg.svh"

// What this block does
// - Frames carry five to nine data bits and one or two stop bits.
// - Synchronous serial clock runs at most half the device clock.
// - Asynchronous bit rate is at most one eighth of the clock.
// - Optional odd or even parity is appended and checked on receive.
// - Overrun and framing errors each set their own status flag.
// - Receiver rejects false starts and votes three samples per bit.
// - Transmit complete, data register empty, receive complete interrupts.
// - Multi-processor mode drops data frames until software is addressed.
// - Master SPI mode: double buffered, bit order selectable, up to half clock.
// - Transmit and receive are buffered so frames run back to back.
// - Fractional baud generator allows non-integer division.
// - Synchronous slave shifts on a serial clock driven from outside.
// - Transmit and receive run at the same time, full duplex.
// - Infrared coder: 3/16 bit pulse, 8-bit fixed pulse, or bypass.
// - Infrared coding works up to 115.2 kbit/s.
// - One infrared coder, attached to this transceiver only when enabled.
module usir_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic txd,
  input wire logic rxd,
  output logic xck_out,
  output logic xck_oe,
  input wire logic xck_in,
  output logic ir_out,
  input wire logic ir_in,
  output logic irq
);

  logic [`USIR_CTRL_W-1:0] ctrl_reg;
  logic [15:0] baud_reg;
  logic [7:0] irpulse_reg;
  logic [`USIR_ST_W-1:0] status_reg, mask_reg, set_vec;
  logic [31:0] prdata_reg, rd_mux;
  logic pready_reg, pslverr_reg, irq_reg, txd_reg, ir_out_reg, xck_reg, xck_out_reg, is_mst_q;
  logic setup, wr, rd, mapped;
  logic [1:0] mode;
  logic is_async, is_spi, is_mst, ir_en, parity_on, odd;
  logic [3:0] nbits, last_idx;
  logic [8:0] dmask;

  // Mode and frame format decode
  assign mode = ctrl_reg[`USIR_F_MODE];
  assign is_async = mode == `USIR_MODE_ASYNC;
  assign is_spi = mode == `USIR_MODE_SPI;
  assign is_mst = mode == `USIR_MODE_SMASTER || is_spi;
  assign ir_en = ctrl_reg[`USIR_F_IREN] && is_async;
  assign parity_on = ctrl_reg[`USIR_F_PAR] == `USIR_PAR_EVEN ||
                     ctrl_reg[`USIR_F_PAR] == `USIR_PAR_ODD;
  assign odd = ctrl_reg[`USIR_F_PAR] == `USIR_PAR_ODD;
  assign nbits = is_spi ? 4'h8 : (ctrl_reg[`USIR_F_SIZE] > 3'h4) ? 4'h9 :
                 {1'b0, ctrl_reg[`USIR_F_SIZE]} + 4'h5;
  assign last_idx = nbits - 4'h1;
  assign dmask = 9'h1ff >> (4'h9 - nbits);

  // APB decode: answer in the access cycle that follows setup
  assign setup = psel && !penable;
  assign wr = psel && penable && pready_reg && pwrite;
  assign rd = psel && penable && pready_reg && !pwrite;
  assign mapped = paddr == `USIR_OFF_DATA || paddr == `USIR_OFF_STATUS ||
                  paddr == `USIR_OFF_MASK || paddr == `USIR_OFF_CTRL ||
                  paddr == `USIR_OFF_BAUD || paddr == `USIR_OFF_IRPULSE;

  // Fractional baud generator
  logic [11:0] brg_cnt, div_m1;
  logic [3:0] brg_acc;
  logic [4:0] acc_sum;
  logic brg_tick;
  assign div_m1 = (baud_reg[`USIR_F_BINT] == 12'h000) ? 12'h000 :
                  baud_reg[`USIR_F_BINT] - 12'h001;
  assign acc_sum = {1'b0, brg_acc} + {1'b0, baud_reg[`USIR_F_BFRAC]};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brg_cnt <= 12'h000;
      brg_acc <= 4'h0;
      brg_tick <= 1'b0;
    end else if (brg_cnt == 12'h000) begin
      brg_tick <= 1'b1;
      brg_acc <= acc_sum[3:0];
      brg_cnt <= div_m1 + {11'h000, acc_sum[4]};
    end else begin
      brg_tick <= 1'b0;
      brg_cnt <= brg_cnt - 12'h001;
    end
  end

  // Transmitter state
  usir_pkg::usir_frame_t tx_state;
  logic [8:0] tx_buf, tx_sh;
  logic tx_full, tx_stop2nd;
  logic [3:0] tx_idx, tx_pos;
  logic [2:0] tx_ph;
  logic tx_step, tx_load, tx_end, line_val;
  logic xck_q, rise_m, fall_m, rise_d1, rise_d2, sync_rise, sync_fall, xck_run;

  // Serial clock: master toggles on baud ticks, slave edges from the pin
  assign xck_run = mode == `USIR_MODE_SMASTER || (is_spi && tx_state != usir_pkg::usir_idle);
  assign rise_m = brg_tick && xck_run && !xck_reg;
  assign fall_m = brg_tick && xck_reg;
  assign sync_rise = (mode == `USIR_MODE_SSLAVE) ? (xck_in && !xck_q) : rise_d2;
  assign sync_fall = (mode == `USIR_MODE_SSLAVE) ? (!xck_in && xck_q) : fall_m;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xck_reg <= 1'b0;
      xck_out_reg <= 1'b0;
      xck_q <= 1'b0;
      rise_d1 <= 1'b0;
      rise_d2 <= 1'b0;
    end else begin
      xck_reg <= is_mst && (rise_m || (xck_reg && !fall_m));
      xck_out_reg <= xck_reg;
      xck_q <= xck_in;
      rise_d1 <= rise_m && is_mst;
      rise_d2 <= rise_d1;
    end
  end

  assign tx_step = is_async ? (brg_tick && tx_ph == `USIR_PH_LAST) : sync_fall;
  assign tx_end = tx_step && ((tx_state == usir_pkg::usir_stop &&
                  (tx_stop2nd || !ctrl_reg[`USIR_F_STOP2])) ||
                  (is_spi && tx_state == usir_pkg::usir_data && tx_idx == last_idx));
  assign tx_load = tx_full && ctrl_reg[`USIR_F_TXEN] &&
                   (tx_state == usir_pkg::usir_idle || tx_end);
  assign tx_pos = (is_spi && !ctrl_reg[`USIR_F_LSBF]) ? last_idx - tx_idx : tx_idx;

  // Line value of the current bit cell
  always_comb begin
    case (tx_state)
      usir_pkg::usir_idle: line_val = 1'b1;
      usir_pkg::usir_start: line_val = 1'b0;
      usir_pkg::usir_data: line_val = tx_sh[tx_pos];
      usir_pkg::usir_par: line_val = ^(tx_sh & dmask) ^ odd;
      usir_pkg::usir_stop: line_val = 1'b1;
      default: line_val = 1'b1;
    endcase
  end

  // Transmit buffer and shifter sequence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= usir_pkg::usir_idle;
      tx_buf <= 9'h000;
      tx_sh <= 9'h000;
      tx_full <= 1'b0;
      tx_idx <= 4'h0;
      tx_ph <= 3'h0;
      tx_stop2nd <= 1'b0;
    end else begin
      if (wr && paddr == `USIR_OFF_DATA && (!tx_full || tx_load)) begin
        tx_buf <= pwdata[8:0];
        tx_full <= 1'b1;
      end else if (tx_load) begin
        tx_full <= 1'b0;
      end
      if (brg_tick) begin
        tx_ph <= tx_ph + 3'h1;
      end
      if (tx_load) begin
        tx_sh <= tx_buf;
        tx_idx <= 4'h0;
        tx_ph <= 3'h0;
        tx_stop2nd <= 1'b0;
        tx_state <= is_spi ? usir_pkg::usir_data : usir_pkg::usir_start;
      end else if (tx_end) begin
        tx_state <= usir_pkg::usir_idle;
      end else if (tx_step) begin
        case (tx_state)
          usir_pkg::usir_start: tx_state <= usir_pkg::usir_data;
          usir_pkg::usir_data: begin
            tx_idx <= tx_idx + 4'h1;
            if (tx_idx == last_idx) begin
              tx_state <= parity_on ? usir_pkg::usir_par : usir_pkg::usir_stop;
            end
          end
          usir_pkg::usir_par: tx_state <= usir_pkg::usir_stop;
          usir_pkg::usir_stop: tx_stop2nd <= 1'b1;
          default: tx_state <= usir_pkg::usir_idle;
        endcase
      end
    end
  end

  // Infrared pulse coder, attached only when enabled
  logic [13:0] ir_cnt, ir_len;
  logic ir_trig, ir_q1, ir_q2, ir_pulse;
  logic [3:0] ir_lo_cnt;
  assign ir_len = (ctrl_reg[`USIR_F_IRSEL] == `USIR_IR_FIXED) ?
                  ((irpulse_reg == 8'h00) ? 14'h0001 : {6'h00, irpulse_reg}) :
                  ((baud_reg[`USIR_F_BINT] < 12'h002) ? 14'h0001 :
                   14'((baud_reg[`USIR_F_BINT] * 3) >> 1));
  assign ir_trig = ir_en && brg_tick && tx_ph == 3'h0 && !line_val &&
                   tx_state != usir_pkg::usir_idle;
  assign ir_pulse = ir_in && ir_q1 && !ir_q2; // Pulses shorter than two cycles dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_cnt <= 14'h0000;
      ir_q1 <= 1'b0;
      ir_q2 <= 1'b0;
      ir_lo_cnt <= 4'h0;
    end else begin
      ir_q1 <= ir_in;
      ir_q2 <= ir_q1;
      if (ir_trig) begin
        ir_cnt <= ir_len;
      end else if (ir_cnt != 14'h0000) begin
        ir_cnt <= ir_cnt - 14'h0001;
      end
      if (ir_pulse) begin
        ir_lo_cnt <= `USIR_IR_LOW_TICKS;
      end else if (brg_tick && ir_lo_cnt != 4'h0) begin
        ir_lo_cnt <= ir_lo_cnt - 4'h1;
      end
    end
  end

  // Receiver: majority vote, false start rejection, frame assembly
  usir_pkg::usir_frame_t rx_state;
  logic [8:0] rx_sh, rx_sh_next, rx_buf;
  logic [3:0] rx_idx, rx_pos;
  logic [2:0] rx_ph;
  logic [1:0] rx_votes;
  logic rx_q, rx_line, rx_bit, rx_sample, rx_cap, rx_done, rx_ferr, rx_perr_pend;
  logic rx_full, rx_perr_now, rx_keep, pop;
  assign rx_line = ir_en ? (ir_lo_cnt == 4'h0) : rxd;
  assign rx_sample = is_async ? (brg_tick && rx_ph == `USIR_PH_VOTE) : sync_rise;
  assign rx_bit = is_async ? ((rx_votes[1] & rx_votes[0]) | (rx_votes[1] & rx_q) |
                  (rx_votes[0] & rx_q)) : rx_q;
  assign rx_cap = rx_sample && ctrl_reg[`USIR_F_RXEN] && (rx_state == usir_pkg::usir_data ||
                  (rx_state == usir_pkg::usir_idle && is_spi));
  assign rx_pos = (is_spi && !ctrl_reg[`USIR_F_LSBF]) ? last_idx - rx_idx : rx_idx;
  assign rx_done = (rx_cap && is_spi && rx_idx == last_idx) ||
                   (rx_sample && rx_state == usir_pkg::usir_stop);
  assign rx_ferr = rx_state == usir_pkg::usir_stop && !rx_bit;
  assign rx_keep = !ctrl_reg[`USIR_F_MPCM] || rx_sh_next[last_idx];
  assign pop = rd && paddr == `USIR_OFF_DATA;
  assign rx_perr_now = rx_perr_pend && rx_state == usir_pkg::usir_stop;
  always_comb begin
    rx_sh_next = rx_sh;
    if (rx_cap) begin
      rx_sh_next[rx_pos] = rx_bit;
    end
  end

  // Receive sequence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state <= usir_pkg::usir_idle;
      rx_q <= 1'b1;
      rx_votes <= 2'h3;
      rx_ph <= 3'h0;
      rx_idx <= 4'h0;
      rx_sh <= 9'h000;
      rx_perr_pend <= 1'b0;
    end else begin
      rx_q <= rx_line;
      if (brg_tick && rx_ph < `USIR_PH_VOTE) begin
        rx_votes <= {rx_votes[0], rx_q};
      end
      if (brg_tick) begin
        rx_ph <= rx_ph + 3'h1;
      end
      rx_sh <= rx_sh_next;
      if (!ctrl_reg[`USIR_F_RXEN]) begin
        rx_state <= usir_pkg::usir_idle;
        rx_idx <= 4'h0;
      end else if (rx_done) begin
        rx_state <= usir_pkg::usir_idle;
        rx_idx <= 4'h0;
      end else if (rx_state == usir_pkg::usir_idle && is_async && !rx_q) begin
        rx_state <= usir_pkg::usir_start;
        rx_ph <= 3'h0;
      end else if (rx_cap) begin
        rx_idx <= rx_idx + 4'h1;
        rx_state <= usir_pkg::usir_data;
        if (rx_idx == last_idx) begin
          rx_state <= parity_on ? usir_pkg::usir_par : usir_pkg::usir_stop;
        end
      end else if (rx_sample) begin
        case (rx_state)
          usir_pkg::usir_idle: if (!rx_bit) rx_state <= usir_pkg::usir_data;
          usir_pkg::usir_start: begin
            rx_state <= rx_bit ? usir_pkg::usir_idle : usir_pkg::usir_data;
          end
          usir_pkg::usir_par: begin
            rx_perr_pend <= ^(rx_sh & dmask) ^ odd ^ rx_bit;
            rx_state <= usir_pkg::usir_stop;
          end
          default: rx_state <= rx_state;
        endcase
      end
      if (rx_state == usir_pkg::usir_idle) begin
        rx_perr_pend <= 1'b0;
      end
    end
  end

  // Receive buffer; a completed frame wins over a read in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_buf <= 9'h000;
      rx_full <= 1'b0;
    end else if (rx_done && rx_keep && (!rx_full || pop)) begin
      rx_buf <= rx_sh_next & dmask;
      rx_full <= 1'b1;
    end else if (pop) begin
      rx_full <= 1'b0;
    end
  end

  // Event vector for the sticky status bits
  always_comb begin
    set_vec = '0;
    set_vec[`USIR_ST_RXC] = rx_done && rx_keep && (!rx_full || pop);
    set_vec[`USIR_ST_TXC] = tx_end && !tx_full;
    set_vec[`USIR_ST_DRE] = tx_load;
    set_vec[`USIR_ST_FERR] = set_vec[`USIR_ST_RXC] && rx_ferr;
    set_vec[`USIR_ST_PERR] = set_vec[`USIR_ST_RXC] && rx_perr_now;
    set_vec[`USIR_ST_OVF] = rx_done && rx_keep && rx_full && !pop;
  end

  // Read data multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `USIR_OFF_DATA: rd_mux[8:0] = rx_buf;
      `USIR_OFF_STATUS: rd_mux[10:0] = {tx_state != usir_pkg::usir_idle, !tx_full,
                                       rx_full, 2'h0, status_reg};
      `USIR_OFF_MASK: rd_mux[`USIR_ST_W-1:0] = mask_reg;
      `USIR_OFF_CTRL: rd_mux[`USIR_CTRL_W-1:0] = ctrl_reg;
      `USIR_OFF_BAUD: rd_mux[15:0] = baud_reg;
      `USIR_OFF_IRPULSE: rd_mux[7:0] = irpulse_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Register writes and bus answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `USIR_CTRL_RST;
      baud_reg <= `USIR_BAUD_RST;
      irpulse_reg <= `USIR_IRPULSE_RST;
      mask_reg <= `USIR_MASK_RST;
      status_reg <= '0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      end
      if (wr && paddr == `USIR_OFF_CTRL) ctrl_reg <= pwdata[`USIR_CTRL_W-1:0];
      if (wr && paddr == `USIR_OFF_BAUD) baud_reg <= pwdata[15:0];
      if (wr && paddr == `USIR_OFF_IRPULSE) irpulse_reg <= pwdata[7:0];
      if (wr && paddr == `USIR_OFF_MASK) mask_reg <= pwdata[`USIR_ST_W-1:0];
      status_reg <= (status_reg & ~((wr && paddr == `USIR_OFF_STATUS) ?
                    pwdata[`USIR_ST_W-1:0] : '0)) | set_vec;
    end
  end

  // Pin and interrupt outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txd_reg <= 1'b1;
      ir_out_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      txd_reg <= ir_en ? 1'b1 : line_val;
      ir_out_reg <= ir_en && ((ctrl_reg[`USIR_F_IRSEL] == `USIR_IR_BYPASS) ? !line_val :
                    (ir_trig || ir_cnt > 14'h0001));
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign txd = txd_reg;
  assign xck_out = xck_out_reg;
  assign xck_oe = is_mst_q;
  assign ir_out = ir_out_reg;
  assign irq = irq_reg;

  // Drive enable of the serial clock pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) is_mst_q <= 1'b0;
    else is_mst_q <= is_mst;
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_bit_spacing;
    tx_step && is_async |=> !tx_step [*7];
  endproperty
  a_bit_spacing: assert property (p_bit_spacing) else $error("async bit shorter than 8 clocks");

  property p_xck_half;
    $changed(xck_reg) |-> $past(brg_tick) || !$past(is_mst);
  endproperty
  a_xck_half: assert property (p_xck_half) else $error("serial clock faster than half");

  property p_start_low;
    tx_load && !is_spi && !ir_en |=> ##1 !txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_ovf;
    set_vec[`USIR_ST_OVF] |=> status_reg[`USIR_ST_OVF] && rx_full;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overrun not flagged");

  property p_ferr;
    rx_done && rx_ferr && rx_keep && !rx_full |=> status_reg[`USIR_ST_FERR];
  endproperty
  a_ferr: assert property (p_ferr) else $error("framing error not flagged");

  property p_mpcm_drop;
    rx_done && !rx_keep |=> $stable(rx_buf) && !$rose(status_reg[`USIR_ST_RXC]);
  endproperty
  a_mpcm_drop: assert property (p_mpcm_drop) else $error("unaddressed frame kept");

  property p_dre;
    tx_load |=> status_reg[`USIR_ST_DRE] && tx_state != usir_pkg::usir_idle;
  endproperty
  a_dre: assert property (p_dre) else $error("data register empty missing");

  property p_irq;
    (|(status_reg & mask_reg)) [*2] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_par_cell;
    tx_state == usir_pkg::usir_data && tx_step && tx_idx == last_idx && !is_spi
      |=> tx_state == (parity_on ? usir_pkg::usir_par : usir_pkg::usir_stop);
  endproperty
  a_par_cell: assert property (p_par_cell) else $error("parity cell misplaced");

  property p_ir_idle;
    !ir_en |=> !ir_out;
  endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("coder drives while detached");

  c_back_to_back: cover property (tx_end ##1 tx_state == usir_pkg::usir_start);
  c_overrun: cover property (set_vec[`USIR_ST_OVF]);
  c_false_start: cover property (rx_state == usir_pkg::usir_start ##1 rx_state == usir_pkg::usir_idle);
  c_spi_frame: cover property (is_spi && rx_done);

endmodule : usir_top
`default_nettype wire

// ===== dv/usir_far_end.sv
/*
  Far-end serial partner: sends and captures asynchronous frames.
  Assumes a bit time of BIT clk cycles and a line that idles high.
*/
`timescale 1ns/100ps
`default_nettype none
module usir_far_end #(
  parameter int BIT = 32
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  logic [9:0] got;
  int rx_n = 8;
  // Line idles high
  initial line_out = 1'b1;
  // Start bit, n bits LSB first, stop level, then idle
  task automatic send(input logic [9:0] bits, input int n, input logic stp);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (BIT) @(posedge clk);
    end
    line_out <= stp;
    repeat (BIT) @(posedge clk);
    line_out <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask : send
  // Capture each frame at mid bit
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < rx_n; i++) begin
      repeat (BIT) @(posedge clk);
      got[i] = line_in;
    end
    repeat (BIT) @(posedge clk);
  end
endmodule : usir_far_end
`default_nettype wire

// ===== dv/tb_top.sv
/*
  Testbench of the serial transceiver: APB master, far-end partner.
  Assumes zero wait state APB and a bit cell of 8 ticks of BINT clocks.
*/
`timescale 1ns/100ps
`default_nettype none
`include "usir_cfg.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, txd, rxd, e, irq;
  logic xck_out, xck_oe, ir_out;
  logic xck_d = 1'b0;
  int xck_rises = 0;
  int ir_highs = 0;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  // Rows of {address, reset value, error}
  logic [44:0] rows [5] = '{{`USIR_OFF_CTRL, 32'h0, 1'b0}, {`USIR_OFF_BAUD, 32'h10, 1'b0},
    {`USIR_OFF_IRPULSE, 32'h10, 1'b0}, {`USIR_OFF_MASK, 32'h0, 1'b0}, {12'h018, 32'h0, 1'b1}};
  usir_top i_usir_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd(txd), .rxd(rxd), .xck_out(xck_out), .xck_oe(xck_oe),
    .xck_in(1'b0), .ir_out(ir_out), .ir_in(1'b0), .irq(irq));
  usir_far_end #(.BIT(32)) i_usir_far_end (.clk(clk), .line_in(txd), .line_out(rxd));
  // Clock at 5 ns period
  initial forever #2.5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      end_sim();
    end
  end
  // Serial clock rises and infrared pulse cycles seen so far
  always @(posedge clk) begin
    xck_d <= xck_out;
    if (xck_out && !xck_d) xck_rises++;
    if (ir_out) ir_highs++;
  end
  // One APB transfer, result in q and e
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // Poll status until a bit is set, then compare it
  task automatic wait_bit(input int b);
    q = 32'h0;
    for (int i = 0; i < 300 && q[b] !== 1'b1; i++) apb(1'b0, `USIR_OFF_STATUS, 32'h0);
    chk(q[b], 1'b1);
  endtask : wait_bit
  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    chk(txd, 1'b1);
    foreach (rows[i]) begin
      apb(1'b0, rows[i][44:33], 32'h0);
      chk(q, rows[i][32:1]);
      chk(e, rows[i][0]);
    end
    $display("test 1 done");
    // 8N1, tick of 4 clocks, send and receive at once
    apb(1'b1, `USIR_OFF_BAUD, 32'h4);
    apb(1'b1, `USIR_OFF_CTRL, 32'h33);
    fork
      apb(1'b1, `USIR_OFF_DATA, 32'ha5);
      i_usir_far_end.send(10'h03c, 8, 1'b1);
    join
    repeat (400) @(posedge clk);
    chk(i_usir_far_end.got[7:0], 8'ha5);
    apb(1'b0, `USIR_OFF_STATUS, 32'h0);
    chk(q & 32'h3, 32'h3);
    apb(1'b0, `USIR_OFF_DATA, 32'h0);
    chk(q, 32'h3c);
    $display("test 2 done");
    // Even parity on send, bad parity on receive
    apb(1'b1, `USIR_OFF_CTRL, 32'h233);
    i_usir_far_end.rx_n = 9;
    apb(1'b1, `USIR_OFF_DATA, 32'h07);
    i_usir_far_end.send(10'h103, 9, 1'b1);
    repeat (100) @(posedge clk);
    chk(i_usir_far_end.got[8:0], 9'h107);
    wait_bit(`USIR_ST_PERR);
    $display("test 3 done");
    // Low stop bit
    i_usir_far_end.rx_n = 8;
    apb(1'b1, `USIR_OFF_CTRL, 32'h33);
    apb(1'b1, `USIR_OFF_STATUS, 32'h3f);
    apb(1'b0, `USIR_OFF_DATA, 32'h0);
    i_usir_far_end.send(10'h055, 8, 1'b0);
    wait_bit(`USIR_ST_FERR);
    // Unread frames overrun the buffer
    repeat (3) i_usir_far_end.send(10'h011, 8, 1'b1);
    wait_bit(`USIR_ST_OVF);
    $display("test 4 done");
    // Receive interrupt raised and cleared
    apb(1'b0, `USIR_OFF_DATA, 32'h0);
    apb(1'b0, `USIR_OFF_DATA, 32'h0);
    apb(1'b1, `USIR_OFF_STATUS, 32'h3f);
    apb(1'b1, `USIR_OFF_MASK, 32'h1);
    chk(irq, 1'b0);
    i_usir_far_end.send(10'h022, 8, 1'b1);
    wait_bit(`USIR_ST_RXC);
    chk(irq, 1'b1);
    apb(1'b1, `USIR_OFF_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("test 5 done");
    // Nine bits, data frame dropped until addressed
    apb(1'b0, `USIR_OFF_DATA, 32'h0);
    apb(1'b1, `USIR_OFF_CTRL, 32'h443);
    i_usir_far_end.send(10'h0ff, 9, 1'b1);
    apb(1'b0, `USIR_OFF_STATUS, 32'h0);
    chk(q[`USIR_ST_RXC], 1'b0);
    i_usir_far_end.send(10'h1aa, 9, 1'b1);
    wait_bit(`USIR_ST_RXC);
    apb(1'b0, `USIR_OFF_DATA, 32'h0);
    chk(q, 32'h1aa);
    $display("test 6 done");
    // Infrared 3/16 pulse on the start bit only, line pin held high
    apb(1'b1, `USIR_OFF_CTRL, 32'h1033);
    apb(1'b1, `USIR_OFF_DATA, 32'hff);
    repeat (20) @(posedge clk);
    chk(txd, 1'b1);
    repeat (400) @(posedge clk);
    chk(ir_highs, 32'h6);
    chk(xck_oe, 1'b0);
    $display("test 7 done");
    // Master SPI byte, eight clock rises, idle receive line reads ones
    apb(1'b1, `USIR_OFF_CTRL, 32'hf);
    apb(1'b1, `USIR_OFF_STATUS, 32'h3f);
    apb(1'b1, `USIR_OFF_DATA, 32'h5a);
    wait_bit(`USIR_ST_RXC);
    apb(1'b0, `USIR_OFF_DATA, 32'h0);
    chk(q, 32'hff);
    chk(xck_rises, 32'h8);
    chk(xck_oe, 1'b1);
    $display("test 8 done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
